// File: rtl/csp_chopper_setup.sv
`timescale 1ns/1ps
module csp_chopper_setup #(
  parameter int unsigned TEST_PHASE_CYCLES = csp_pkg::TEST_PHASE_CYCLES
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_b,
  // Command link from the host.
  input wire logic cmd_valid,
  input wire csp_pkg::csp_cmd_t cmd,
  output logic cmd_ready,
  // Answers to the host.
  output logic rsp_valid,
  output csp_pkg::csp_rsp_t rsp,
  // External sync input.
  input wire logic sync_in,
  // Front panel and motor.
  output logic led_blink,
  output logic display_pass,
  output logic motor_drive,
  // Active configuration.
  output csp_pkg::csp_setup_t setup,
  output logic [3:0] store_slot_select,
  output logic [3:0] recall_slot_select
);

  typedef enum logic [4:0] {
    ST_TEST = 5'b00001,
    ST_PASS = 5'b00010,
    ST_LOAD = 5'b00100,
    ST_APPLY = 5'b01000,
    ST_RUN = 5'b10000
  } csp_state_t;

  // A short self-test phase blinks on the lowest counter bit so the lamps still toggle.
  localparam int unsigned BLINK_SEL = (csp_pkg::BLINK_BIT < $clog2(TEST_PHASE_CYCLES)) ? csp_pkg::BLINK_BIT : 32'h0;

  csp_state_t state;
  csp_state_t next_state;
  logic [31:0] test_cnt;
  logic [3:0] load_addr;
  logic last_dirty;
  logic in_range;
  csp_pkg::csp_mem_word_t rd_data;

  // Command decode.
  wire take = cmd_valid && cmd_ready;
  wire is_set = take && !cmd.query;
  wire is_store_slot = (cmd.code == csp_pkg::CMD_STORE_SLOT);
  wire is_recall_slot = (cmd.code == csp_pkg::CMD_RECALL_SLOT);
  wire is_harmonic = (cmd.code == csp_pkg::CMD_HARMONIC);
  wire is_sub = (cmd.code == csp_pkg::CMD_SUBHARMONIC);
  wire is_sync = (cmd.code == csp_pkg::CMD_SYNC);
  wire is_wheel = (cmd.code == csp_pkg::CMD_WHEEL);
  wire is_mode = (cmd.code == csp_pkg::CMD_MODE);
  wire is_mem = (cmd.code == csp_pkg::CMD_MEMORY);

  // Range check per command; a failing set changes nothing.
  wire store_ok = (cmd.value >= csp_pkg::STORE_SLOT_MIN) && (cmd.value <= csp_pkg::STORE_SLOT_MAX); // [RQ1]
  wire recall_ok = (cmd.value <= csp_pkg::RECALL_SLOT_MAX); // [RQ12]
  wire ratio_ok = (cmd.value >= csp_pkg::RATIO_MIN) && (cmd.value <= csp_pkg::RATIO_MAX); // [RQ4] [RQ13]
  wire sync_ok = (cmd.value <= csp_pkg::SYNC_MAX); // [RQ5]
  wire wheel_ok = (cmd.value <= csp_pkg::WHEEL_MAX); // [RQ6]
  wire mode_ok = (cmd.value <= csp_pkg::MODE_MAX);
  wire mem_ok = (cmd.value <= csp_pkg::MEM_MAX);
  wire value_ok = (is_store_slot && store_ok) || (is_recall_slot && recall_ok) ||
                  ((is_harmonic || is_sub) && ratio_ok) || (is_sync && sync_ok) ||
                  (is_wheel && wheel_ok) || (is_mode && mode_ok) || (is_mem && mem_ok);
  wire set_go = is_set && value_ok; // [RQ14]
  wire cfg_go = set_go && (is_harmonic || is_sub || is_sync || is_wheel || is_mode);
  wire store_go = set_go && is_mem && (cmd.value == csp_pkg::MEM_OP_STORE); // [RQ3]
  wire recall_go = set_go && is_mem && (cmd.value == csp_pkg::MEM_OP_RECALL); // [RQ12]
  wire recall_factory = (load_addr == csp_pkg::FACTORY_SLOT);

  // Restored word: factory slot and never-written locations give defaults.
  wire use_stored = !recall_factory && (rd_data.valid == 1'b1);
  wire csp_pkg::csp_setup_t loaded = use_stored ? rd_data.setup : csp_pkg::FACTORY_SETUP; // [RQ12]
  wire apply_go = (state == ST_APPLY);

  // Next configuration: the restored word in ST_APPLY, otherwise from a set command.
  csp_pkg::csp_setup_t next_setup;
  always_comb begin
    next_setup = setup;
    if (apply_go) begin
      next_setup = loaded;
    end else if (cfg_go) begin
      if (is_harmonic) begin
        next_setup.harmonic = cmd.value; // [RQ13]
      end
      if (is_sub) begin
        next_setup.subharmonic = cmd.value; // [RQ4]
      end
      if (is_sync) begin
        next_setup.sync = cmd.value[1:0]; // [RQ5]
      end
      if (is_wheel) begin
        next_setup.wheel = cmd.value[2:0]; // [RQ6]
      end
      if (is_mode) begin
        next_setup.mode = cmd.value[1:0];
      end
    end
  end

  // Query answer carries the command code and the value in set form.
  logic [3:0] query_value;
  always_comb begin
    query_value = 4'h0;
    unique case (cmd.code)
      csp_pkg::CMD_STORE_SLOT: query_value = store_slot_select; // [RQ2]
      csp_pkg::CMD_RECALL_SLOT: query_value = recall_slot_select;
      csp_pkg::CMD_HARMONIC: query_value = setup.harmonic;
      csp_pkg::CMD_SUBHARMONIC: query_value = setup.subharmonic;
      csp_pkg::CMD_SYNC: query_value = {2'h0, setup.sync};
      csp_pkg::CMD_WHEEL: query_value = {1'h0, setup.wheel};
      csp_pkg::CMD_MODE: query_value = {2'h0, setup.mode};
      csp_pkg::CMD_MEMORY: query_value = 4'h0;
      default: query_value = 4'h0;
    endcase
  end

  wire csp_pkg::csp_rsp_t next_rsp = '{code: cmd.code, value: cmd.query ? query_value : cmd.value,
                                       error: !cmd.query && !value_ok}; // [RQ7]

  // Memory: store to the selected slot wins; the last-active copy follows later.
  wire mem_we = store_go || last_dirty;
  wire [3:0] mem_wr_addr = store_go ? store_slot_select : csp_pkg::LAST_ACTIVE_ADDR; // [RQ3]
  wire csp_pkg::csp_mem_word_t mem_wr_data = '{valid: 1'b1, setup: setup};
  wire setup_changes = cfg_go || apply_go;

  // Start-up sequence: blink, show pass, then restore the last active set-up.
  wire test_done = (test_cnt >= TEST_PHASE_CYCLES - 1);
  always_comb begin
    next_state = state;
    unique case (state)
      ST_TEST: next_state = test_done ? ST_PASS : ST_TEST; // [RQ8]
      ST_PASS: next_state = test_done ? ST_LOAD : ST_PASS; // [RQ8]
      ST_LOAD: next_state = ST_APPLY;
      ST_APPLY: next_state = ST_RUN;
      ST_RUN: next_state = recall_go ? ST_LOAD : ST_RUN;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_TEST;
      test_cnt <= 32'h0000_0000;
    end else begin
      state <= next_state;
      test_cnt <= (next_state != state) ? 32'h0000_0000 : test_cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      load_addr <= csp_pkg::LAST_ACTIVE_ADDR;
    end else if (recall_go) begin
      load_addr <= recall_slot_select; // [RQ12]
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      setup <= csp_pkg::FACTORY_SETUP;
      store_slot_select <= csp_pkg::STORE_SLOT_MIN;
      recall_slot_select <= csp_pkg::FACTORY_SLOT;
    end else begin
      setup <= next_setup;
      if (set_go && is_store_slot) begin
        store_slot_select <= cmd.value; // [RQ1]
      end
      if (set_go && is_recall_slot) begin
        recall_slot_select <= cmd.value; // [RQ12]
      end
    end
  end

  // A new change sets the dirty flag even in the cycle its write happens.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      last_dirty <= 1'b0;
    end else begin
      last_dirty <= setup_changes || (last_dirty && store_go);
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cmd_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp <= '0;
    end else begin
      cmd_ready <= (next_state == ST_RUN);
      rsp_valid <= take;
      if (take) begin
        rsp <= next_rsp; // [RQ7]
      end
    end
  end

  wire ext_sync = (setup.sync == csp_pkg::SYNC_EXT_RISE) || (setup.sync == csp_pkg::SYNC_EXT_FALL);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      led_blink <= 1'b0;
      display_pass <= 1'b0;
      motor_drive <= 1'b0;
    end else begin
      led_blink <= (state == ST_TEST) && test_cnt[BLINK_SEL]; // [RQ8]
      display_pass <= (state == ST_PASS); // [RQ8]
      motor_drive <= (state == ST_RUN) && (!ext_sync || in_range); // [RQ9]
    end
  end

  csp_setup_mem u_mem (
    .clock(clock),
    .we(mem_we),
    .wr_addr(mem_wr_addr),
    .wr_data(mem_wr_data),
    .rd_addr(load_addr),
    .rd_data(rd_data)
  );

  csp_sync_window u_window (
    .clock(clock),
    .rst_b(rst_b),
    .sync_in(sync_in),
    .setup(setup),
    .in_range(in_range)
  );

endmodule : csp_chopper_setup

// File: rtl/csp_pkg.sv
// What this block does
// (RQ1) Store-slot select takes a location from one to nine as the next store target.
// (RQ2) Querying store-slot select returns the location currently chosen for storage.
// (RQ3) Host selects a store slot, then memory store writes the whole configuration there.
// (RQ4) Subharmonic divisor S is set and reported, integer one to fifteen.
// (RQ5) Sync source codes: 0 voltage control, 1 rising edge, 2 falling edge, 3 internal.
// (RQ6) Wheel codes: 0 is 60, 1 is 42/30, 2 is 7/5, 3 is 2, 4 is 100 slots.
// (RQ7) A query answers with the command code and current value, as used to set it.
// (RQ8) At power-up blink indicators, show pass, then restore the last active set-up.
// (RQ9) Stop driving the motor when external sync frequency is outside the wheel range.
// (RQ10) The allowed sync window follows mode, harmonic multiplier, subharmonic divisor and wheel.
// (RQ11) External sync pulses stay active for at least one microsecond.
// (RQ12) Memory recall restores the recall-slot location; location zero gives factory defaults.
// (RQ13) Harmonic multiplier H is set and reported, integer one to fifteen.
// (RQ14) A set with an out-of-range value is rejected and the old setting kept.
package csp_pkg;

  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned TEST_PHASE_MS = 500;
  localparam int unsigned TEST_PHASE_CYCLES = (CLK_HZ / 1000) * TEST_PHASE_MS;
  localparam int unsigned BLINK_BIT = 22;
  localparam int unsigned SYNC_MIN_PULSE_NS = 1000;
  localparam int unsigned SYNC_MIN_PULSE_CYCLES = (SYNC_MIN_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [7:0] SYNC_FILTER_CYCLES = 8'(SYNC_MIN_PULSE_CYCLES / 2);
  localparam logic [31:0] PERIOD_MAX = 32'hffff_ffff;

  localparam logic [3:0] STORE_SLOT_MIN = 4'h1;
  localparam logic [3:0] STORE_SLOT_MAX = 4'h9;
  localparam logic [3:0] RECALL_SLOT_MAX = 4'h9;
  localparam logic [3:0] RATIO_MIN = 4'h1;
  localparam logic [3:0] RATIO_MAX = 4'hf;
  localparam logic [3:0] SYNC_MAX = 4'h3;
  localparam logic [3:0] WHEEL_MAX = 4'h4;
  localparam logic [3:0] MODE_MAX = 4'h2;
  localparam logic [3:0] MEM_MAX = 4'h1;
  localparam logic [3:0] LAST_ACTIVE_ADDR = 4'ha;
  localparam logic [3:0] FACTORY_SLOT = 4'h0;
  localparam int unsigned MEM_DEPTH = 16;

  localparam logic [1:0] MODE_HARMONIC_RATIO = 2'h0;
  localparam logic [1:0] MODE_SUM_DIFF = 2'h1;
  localparam logic [1:0] MODE_NORMAL = 2'h2;
  localparam logic [1:0] SYNC_EXTERNAL_VOLTAGE_CONTROL = 2'h0;
  localparam logic [1:0] SYNC_EXT_RISE = 2'h1;
  localparam logic [1:0] SYNC_EXT_FALL = 2'h2;
  localparam logic [1:0] SYNC_INTERNAL = 2'h3;
  localparam logic [3:0] MEM_OP_STORE = 4'h0;
  localparam logic [3:0] MEM_OP_RECALL = 4'h1;

  // Allowed outer_track_frequency per wheel code, in hertz.
  localparam logic [13:0] WHEEL_FMIN_HZ [0:4] = '{14'h0078, 14'h0054, 14'h000e, 14'h0004, 14'h00c8};
  localparam logic [13:0] WHEEL_FMAX_HZ [0:4] = '{14'h1900, 14'h1180, 14'h02ea, 14'h00d5, 14'h299a};

  typedef enum logic [3:0] {
    CMD_STORE_SLOT = 4'h0,
    CMD_RECALL_SLOT = 4'h1,
    CMD_HARMONIC = 4'h2,
    CMD_SUBHARMONIC = 4'h3,
    CMD_SYNC = 4'h4,
    CMD_WHEEL = 4'h5,
    CMD_MODE = 4'h6,
    CMD_MEMORY = 4'h7
  } csp_cmd_code_t;

  typedef struct packed {
    logic [1:0] mode;
    logic [3:0] harmonic;
    logic [3:0] subharmonic;
    logic [1:0] sync;
    logic [2:0] wheel;
  } csp_setup_t;

  typedef struct packed {
    logic valid;
    csp_setup_t setup;
  } csp_mem_word_t;

  typedef struct packed {
    csp_cmd_code_t code;
    logic query;
    logic [3:0] value;
  } csp_cmd_t;

  typedef struct packed {
    csp_cmd_code_t code;
    logic [3:0] value;
    logic error;
  } csp_rsp_t;

  localparam csp_setup_t FACTORY_SETUP = '{mode: MODE_NORMAL, harmonic: 4'h1, subharmonic: 4'h1,
                                           sync: SYNC_INTERNAL, wheel: 3'h0};

endpackage : csp_pkg

// File: rtl/csp_setup_mem.sv
`timescale 1ns/1ps
module csp_setup_mem (
  // Clock.
  input wire logic clock,
  // Write port.
  input wire logic we,
  input wire logic [3:0] wr_addr,
  input wire csp_pkg::csp_mem_word_t wr_data,
  // Read port, data one cycle after the address.
  input wire logic [3:0] rd_addr,
  output csp_pkg::csp_mem_word_t rd_data
);

  // Contents are kept across reset, as a non-volatile store would be.
  // At power-on every valid bit is clear, so an empty location reads as never written.
  csp_pkg::csp_mem_word_t mem [0:csp_pkg::MEM_DEPTH-1] = '{default: '0};

  always_ff @(posedge clock) begin
    if (we) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule : csp_setup_mem

// File: rtl/csp_sync_window.sv
`timescale 1ns/1ps
module csp_sync_window (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_b,
  // External sync and configuration.
  input wire logic sync_in,
  input wire csp_pkg::csp_setup_t setup,
  // Result.
  output logic in_range
);

  logic sync_filt;
  logic sync_prev;
  logic [7:0] stable_cnt;
  logic [31:0] period;

  wire wheel_ok = ({1'b0, setup.wheel} <= csp_pkg::WHEEL_MAX);
  wire [2:0] wheel_idx = wheel_ok ? setup.wheel : 3'h0;
  wire hs_mode = (setup.mode == csp_pkg::MODE_HARMONIC_RATIO);
  wire [3:0] h_eff = hs_mode ? setup.harmonic : 4'h1;
  wire [3:0] s_eff = hs_mode ? setup.subharmonic : 4'h1;
  wire [55:0] lhs = 56'(csp_pkg::CLK_HZ) * 56'(h_eff);
  wire [55:0] lo_rhs = 56'(period) * 56'(csp_pkg::WHEEL_FMIN_HZ[wheel_idx]) * 56'(s_eff);
  wire [55:0] hi_rhs = 56'(period) * 56'(csp_pkg::WHEEL_FMAX_HZ[wheel_idx]) * 56'(s_eff);
  // Sync must lie between wheel limits scaled by S/H, compared as periods.
  wire window_ok = (lhs >= lo_rhs) && (lhs <= hi_rhs) && (s_eff != 4'h0) && (h_eff != 4'h0); // [RQ10]
  wire rise = sync_filt && !sync_prev;
  wire fall = !sync_filt && sync_prev;
  wire edge_seen = (setup.sync == csp_pkg::SYNC_EXT_FALL) ? fall : rise;
  wire filt_flip = (sync_in != sync_filt) && (stable_cnt == csp_pkg::SYNC_FILTER_CYCLES);

  // A level must hold half the least pulse width before it counts.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      stable_cnt <= 8'h00;
      sync_filt <= 1'b0;
      sync_prev <= 1'b0;
    end else begin
      stable_cnt <= (sync_in == sync_filt || filt_flip) ? 8'h00 : stable_cnt + 8'h01; // [RQ11]
      sync_filt <= filt_flip ? sync_in : sync_filt;
      sync_prev <= sync_filt;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      period <= 32'h0000_0001;
      in_range <= 1'b0;
    end else if (edge_seen) begin
      period <= 32'h0000_0001;
      in_range <= window_ok; // [RQ9]
    end else if (period == csp_pkg::PERIOD_MAX) begin
      in_range <= 1'b0;
    end else begin
      period <= period + 32'h0000_0001;
    end
  end

endmodule : csp_sync_window

// File: tb/csp_chopper_setup_chk.sv
`timescale 1ns/1ps
module csp_chopper_setup_chk #(
  parameter int unsigned TEST_PHASE_CYCLES = 20
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_b,
  // Command link.
  input wire logic cmd_valid,
  input wire csp_pkg::csp_cmd_t cmd,
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  input wire csp_pkg::csp_rsp_t rsp,
  // Sync, panel, motor and configuration.
  input wire logic sync_in,
  input wire logic led_blink,
  input wire logic display_pass,
  input wire logic motor_drive,
  input wire csp_pkg::csp_setup_t setup,
  input wire logic [3:0] store_slot_select,
  input wire logic [3:0] recall_slot_select
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);

  wire take = cmd_valid && cmd_ready;
  wire ask = take && cmd.query;
  wire set_sto = take && !cmd.query && cmd.code == csp_pkg::CMD_STORE_SLOT;
  wire sto_ok = cmd.value >= csp_pkg::STORE_SLOT_MIN && cmd.value <= csp_pkg::STORE_SLOT_MAX;
  wire set_whl = take && !cmd.query && cmd.code == csp_pkg::CMD_WHEEL;
  wire set_har = take && !cmd.query && cmd.code == csp_pkg::CMD_HARMONIC;

  AST_RSP_AFTER_TAKE: assert property (take |=> rsp_valid)
    else $error("no answer after a taken command");
  AST_RSP_ONLY_TAKEN: assert property (!take |=> !rsp_valid)
    else $error("answer without a taken command");
  AST_STO_SET: assert property (set_sto && sto_ok |=> store_slot_select == $past(cmd.value) && !rsp.error)
    else $error("store slot not taken");
  AST_STO_REJECT: assert property (set_sto && !sto_ok |=> rsp.error && $stable(store_slot_select))
    else $error("bad store slot accepted");
  AST_STO_QUERY: assert property (ask && cmd.code == csp_pkg::CMD_STORE_SLOT |=>
    rsp.value == $past(store_slot_select)) else $error("store slot query wrong");
  AST_SUB_QUERY: assert property (ask && cmd.code == csp_pkg::CMD_SUBHARMONIC |=>
    rsp.value == $past(setup.subharmonic)) else $error("divisor query wrong");
  AST_SYN_QUERY: assert property (ask && cmd.code == csp_pkg::CMD_SYNC |=>
    rsp.value == {2'h0, $past(setup.sync)}) else $error("sync query wrong");
  AST_WHL_REJECT: assert property (set_whl && cmd.value > csp_pkg::WHEEL_MAX |=>
    rsp.error && $stable(setup.wheel)) else $error("bad wheel code accepted");
  AST_HAR_ZERO: assert property (set_har && cmd.value == 4'h0 |=> rsp.error && $stable(setup.harmonic))
    else $error("zero multiplier accepted");
  AST_PASS_BEFORE_RUN: assert property (display_pass |-> !cmd_ready)
    else $error("commands taken while showing pass");
  AST_MOTOR_INTERNAL: assert property ((cmd_ready && setup.sync == csp_pkg::SYNC_INTERNAL) [*3] |-> motor_drive)
    else $error("motor off with internal sync");

  cover property (take && cmd.code == csp_pkg::CMD_MEMORY && cmd.value == 4'h1);
  cover property ($rose(motor_drive));
  cover property (rsp_valid && rsp.error);
endmodule : csp_chopper_setup_chk

bind csp_chopper_setup csp_chopper_setup_chk #(.TEST_PHASE_CYCLES(TEST_PHASE_CYCLES)) u_chk (
  .clock(clock), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
  .rsp_valid(rsp_valid), .rsp(rsp), .sync_in(sync_in), .led_blink(led_blink), .display_pass(display_pass),
  .motor_drive(motor_drive), .setup(setup), .store_slot_select(store_slot_select),
  .recall_slot_select(recall_slot_select));

// File: tb/csp_host_model.sv
`timescale 1ns/1ps
module csp_host_model (
  // Clock.
  input wire logic clock,
  // Command link.
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  input wire csp_pkg::csp_rsp_t rsp,
  output logic cmd_valid,
  output csp_pkg::csp_cmd_t cmd
);
  csp_pkg::csp_rsp_t last_rsp;
  int timeouts = 0;

  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
  end

  // Holds the request until an edge takes it, then collects the one answer.
  task automatic send(input logic [3:0] code, input logic query, input logic [3:0] value);
    int n;
    @(negedge clock);
    cmd_valid = 1'b1;
    cmd = {code, query, value};
    n = 0;
    @(posedge clock);
    while (cmd_ready !== 1'b1 && n < 100) begin
      n++;
      @(posedge clock);
    end
    @(negedge clock);
    cmd_valid = 1'b0;
    // A released link shows the inverse, so a stale value is never read as good.
    cmd = ~cmd;
    while (rsp_valid !== 1'b1 && n < 110) begin
      n++;
      @(negedge clock);
    end
    if (n >= 100) begin
      timeouts++;
    end
    last_rsp = rsp;
  endtask : send
endmodule : csp_host_model

// File: tb/csp_chopper_setup_tb_top.sv
`timescale 1ns/1ps
module csp_chopper_setup_tb_top;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic sync_in = 1'b0;
  logic cmd_valid, cmd_ready, rsp_valid, led_blink, display_pass, motor_drive, seen_pass, seen_blink;
  csp_pkg::csp_cmd_t cmd;
  csp_pkg::csp_rsp_t rsp;
  csp_pkg::csp_setup_t setup;
  logic [3:0] store_slot_select, recall_slot_select;
  int miscompares = 0;
  int samples_checked = 0;
  int sync_period = 0;
  logic [3:0] lo [0:6] = '{4'h1, 4'h0, 4'h1, 4'h1, 4'h0, 4'h0, 4'h0};
  logic [3:0] hi [0:6] = '{4'h9, 4'h9, 4'hf, 4'hf, 4'h3, 4'h4, 4'h2};

  always #4 clock = ~clock;

  csp_chopper_setup #(.TEST_PHASE_CYCLES(20)) i_csp_chopper_setup (
    .clock(clock), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp(rsp), .sync_in(sync_in), .led_blink(led_blink), .display_pass(display_pass),
    .motor_drive(motor_drive), .setup(setup), .store_slot_select(store_slot_select),
    .recall_slot_select(recall_slot_select));

  csp_host_model u_host (
    .clock(clock), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp(rsp), .cmd_valid(cmd_valid), .cmd(cmd));

  always begin
    @(negedge clock);
    if (sync_period > 0) begin
      sync_in = 1'b1;
      repeat (200) @(negedge clock);
      sync_in = 1'b0;
      repeat (sync_period - 201) @(negedge clock);
    end
  end

  task automatic cmp_val(input logic [14:0] got, input logic [14:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : cmp_val

  task automatic set_chk(input logic [3:0] code, input logic [3:0] value, input logic err);
    u_host.send(code, 1'b0, value);
    cmp_val(15'(u_host.last_rsp), 15'({code, value, err}), "set answer");
  endtask : set_chk

  task automatic query_chk(input logic [3:0] code, input logic [3:0] exp);
    u_host.send(code, 1'b1, 4'h0);
    cmp_val(15'(u_host.last_rsp), 15'({code, exp, 1'b0}), "query answer");
  endtask : query_chk

  task automatic boot();
    int n;
    @(negedge clock);
    rst_b = 1'b0;
    repeat (4) @(negedge clock);
    cmp_val(15'(setup), 15'({2'h2, 4'h1, 4'h1, 2'h3, 3'h0}), "reset setup");
    cmp_val(15'({store_slot_select, recall_slot_select}), 15'h10, "reset slots");
    rst_b = 1'b1;
    seen_pass = 1'b0;
    seen_blink = 1'b0;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 200) begin
      @(negedge clock);
      n++;
      if (display_pass === 1'b1) begin
        seen_pass = 1'b1;
      end
      if (led_blink === 1'b1) begin
        seen_blink = 1'b1;
      end
    end
    cmp_val(15'(seen_pass), 15'h1, "pass shown before run");
    cmp_val(15'(seen_blink), 15'h1, "blink during self-test");
    cmp_val(15'({led_blink, display_pass}), 15'h0, "panel quiet in run");
  endtask : boot

  task automatic conclude();
    miscompares += u_host.timeouts;
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude

  initial begin
    repeat (60000) @(posedge clock);
    miscompares++;
    conclude();
  end

  initial begin
    boot();
    for (int c = 0; c < 7; c++) begin
      for (int v = 0; v < 16; v++) begin
        set_chk(4'(c), 4'(v), 1'(v < lo[c] || v > hi[c]));
        if (v >= lo[c]) begin
          query_chk(4'(c), (v > hi[c]) ? hi[c] : 4'(v));
        end
      end
    end
    cmp_val(15'({store_slot_select, recall_slot_select}), 15'h99, "slot selects");
    cmp_val(15'(setup), 15'({2'h2, 4'hf, 4'hf, 2'h3, 3'h4}), "setup after sets");
    set_chk(4'h0, 4'h3, 1'b0);
    set_chk(4'h7, 4'h0, 1'b0);
    set_chk(4'h2, 4'h2, 1'b0);
    set_chk(4'h1, 4'h3, 1'b0);
    set_chk(4'h7, 4'h1, 1'b0);
    query_chk(4'h2, 4'hf);
    cmp_val(15'(setup), 15'({2'h2, 4'hf, 4'hf, 2'h3, 3'h4}), "recalled setup");
    set_chk(4'h1, 4'h0, 1'b0);
    set_chk(4'h7, 4'h1, 1'b0);
    query_chk(4'h5, 4'h0);
    set_chk(4'h7, 4'h2, 1'b1);
    query_chk(4'h7, 4'h0);
    cmp_val(15'(setup), 15'({2'h2, 4'h1, 4'h1, 2'h3, 3'h0}), "factory setup");
    set_chk(4'h5, 4'h2, 1'b0);
    repeat (4) @(negedge clock);
    boot();
    cmp_val(15'(setup), 15'({2'h2, 4'h1, 4'h1, 2'h3, 3'h2}), "restored setup");
    set_chk(4'h5, 4'h4, 1'b0);
    cmp_val(15'(motor_drive), 15'h1, "motor with internal sync");
    set_chk(4'h6, 4'h0, 1'b0);
    set_chk(4'h3, 4'hf, 1'b0);
    set_chk(4'h4, 4'h1, 1'b0);
    repeat (10) @(negedge clock);
    cmp_val(15'(motor_drive), 15'h0, "motor before edges");
    sync_period = 1000;
    repeat (5000) @(negedge clock);
    cmp_val(15'(motor_drive), 15'h1, "motor in window");
    sync_period = 500;
    repeat (3000) @(negedge clock);
    cmp_val(15'(motor_drive), 15'h0, "motor too fast");
    sync_period = 1000;
    repeat (3000) @(negedge clock);
    cmp_val(15'(motor_drive), 15'h1, "motor back in window");
    set_chk(4'h6, 4'h2, 1'b0);
    repeat (3000) @(negedge clock);
    cmp_val(15'(motor_drive), 15'h0, "normal mode window");
    set_chk(4'h6, 4'h0, 1'b0);
    set_chk(4'h4, 4'h2, 1'b0);
    repeat (3000) @(negedge clock);
    cmp_val(15'(motor_drive), 15'h1, "falling edge sync");
    sync_period = 0;
    conclude();
  end
endmodule : csp_chopper_setup_tb_top
